// ===== logic/cspm_consts.svh
`ifndef CSPM_CONSTS_SVH
`define CSPM_CONSTS_SVH

// special function register addresses
`define CSPM_PSW_ADDR        8'hD0
`define CSPM_POWER_CONTROL_ADDR       8'h87

// status word field positions
`define CSPM_PSW_CY          7
`define CSPM_PSW_AC          6
`define CSPM_PSW_F0          5
`define CSPM_PSW_RSH         4
`define CSPM_PSW_RSL         3
`define CSPM_PSW_OV          2
`define CSPM_PSW_F1          1
`define CSPM_PSW_PAR         0

// power control field positions
`define CSPM_POWER_CONTROL_IDLE       0
`define CSPM_POWER_CONTROL_STOP       1
`define CSPM_POWER_CONTROL_RSV_LO     2
`define CSPM_POWER_CONTROL_RSV_HI     7

// reset values
`define CSPM_PSW_RST         7'h00
`define CSPM_POWER_CONTROL_RSV_RST    6'h00
`define CSPM_RDATA_RST       8'h00
`define CSPM_BANK_RST        5'h00
`define CSPM_BANK_PAD        3'h0

// program restart address after any reset
`define CSPM_RESET_VEC       16'h0000

// missing-clock monitor timeout in microseconds, advisory for software
`define CSPM_MCD_TIMEOUT_US  100

// synchroniser lanes
`define CSPM_SYNC_W          3
`define CSPM_SYNC_EXT        0
`define CSPM_SYNC_MCD        1
`define CSPM_SYNC_WAKE       2

`endif

// ===== logic/cspm_pkg.sv
`default_nettype none
package cspm_pkg;

	// power management states
	typedef enum logic [2:0]
	{
		CSPM_RUN,
		CSPM_IDLE,
		CSPM_STOP,
		CSPM_SUSP
	} cspm_state_e;

endpackage
`default_nettype wire

// ===== logic/cspm_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser, one lane per bit, lanes reset low
module cspm_sync
#(
	parameter int W = 1
)
(
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] async_in,
	output var  logic [W-1:0] sync_out
);

	logic [W-1:0] meta_q;   // first stage, read only by second stage

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1)
		begin : g_lane
			// each lane is an independent level crossing
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					meta_q[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_q[i]   <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// ===== logic/cspm_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cspm_consts.svh"

// Behaviour
// - idle bit write enters idle after instruction
// - idle keeps registers and peripherals intact
// - idle gates only the cpu clock
// - enabled interrupt or reset pin ends idle
// - interrupt wake clears idle, resumes, services
// - after return, continue after setting instruction
// - reset ending idle restarts at zero
// - watchdog reset ends idle when enabled
// - stop bit write enters stop after instruction
// - stop halts cpu, clocks, oscillator, peripherals
// - only reset leaves stop, restart at zero
// - missing clock monitor reset ends stop
// - mode bits act on one, read zero
// - suspend stops oscillator until wake event
module cspm_top
	import cspm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_rd,
	output var  logic [7:0]  sfr_rdata,
	input  wire logic        instr_done,
	input  wire logic        irq_pending,
	input  wire logic        ext_rst_pin_n,
	input  wire logic        wdt_rst,
	input  wire logic        mcd_rst,
	input  wire logic        mcd_enable,
	input  wire logic        suspend_req,
	input  wire logic        wake_event,
	input  wire logic        cy_we,
	input  wire logic        cy_in,
	input  wire logic        ac_we,
	input  wire logic        ac_in,
	input  wire logic        ov_we,
	input  wire logic        ov_in,
	input  wire logic [7:0]  acc_value,
	output var  logic [7:0]  psw_value,
	output var  logic [4:0]  bank_base,
	output var  logic        cpu_clk_en,
	output var  logic        sys_clk_en,
	output var  logic        periph_clk_en,
	output var  logic        osc_en,
	output var  logic        core_rst,
	output var  logic [15:0] restart_addr,
	output var  logic        irq_resume,
	output var  logic        mode_idle,
	output var  logic        mode_stop,
	output var  logic        mode_susp
);

	// address match, shared by read and write decode
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
		addr_hit = (a == target);
	endfunction

	// pin-side inputs pass two flops first
	logic [`CSPM_SYNC_W-1:0] async_vec;   // raw pins, active high
	logic [`CSPM_SYNC_W-1:0] sync_vec;    // synchronised pins
	logic                    ext_rst_s;   // reset pin asserted
	logic                    mcd_rst_s;   // monitor reset request
	logic                    wake_s;      // suspend wake event

	assign async_vec[`CSPM_SYNC_EXT]  = ~ext_rst_pin_n;
	assign async_vec[`CSPM_SYNC_MCD]  = mcd_rst;
	assign async_vec[`CSPM_SYNC_WAKE] = wake_event;

	cspm_sync
	#(
		.W (`CSPM_SYNC_W)
	)
	u_sync
	(
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in (async_vec),
		.sync_out (sync_vec)
	);

	assign ext_rst_s = sync_vec[`CSPM_SYNC_EXT];
	assign mcd_rst_s = sync_vec[`CSPM_SYNC_MCD];
	assign wake_s    = sync_vec[`CSPM_SYNC_WAKE];

	// state and storage
	cspm_state_e state_q;          // power state
	cspm_state_e state_d;
	logic [7:1]  psw_q;            // stored status bits, parity is separate
	logic [7:1]  psw_d;
	logic        parity_q;         // registered accumulator parity
	logic [5:0]  power_control_rsv_q;       // reserved bits, plain storage
	logic [5:0]  power_control_rsv_d;
	logic        idle_arm_q;       // idle written, waiting for instruction end
	logic        idle_arm_d;
	logic        stop_arm_q;       // stop written, waiting for instruction end
	logic        stop_arm_d;
	logic [7:0]  rdata_d;

	// decode
	logic cpu_run;                 // cpu is executing
	logic psw_wr;
	logic power_control_wr;
	logic psw_rd;
	logic power_control_rd;
	logic idle_wr_one;
	logic stop_wr_one;
	logic go_idle;
	logic go_stop;
	logic rst_idle;                // any reset that ends idle
	logic rst_stop;                // any reset that ends stop
	logic rst_any;                 // reset seen in current state
	logic wake_irq;

	assign cpu_run     = (state_q == CSPM_RUN);
	assign psw_wr      = sfr_wr & cpu_run & addr_hit(sfr_addr, `CSPM_PSW_ADDR);
	assign power_control_wr     = sfr_wr & cpu_run & addr_hit(sfr_addr, `CSPM_POWER_CONTROL_ADDR);
	assign psw_rd      = sfr_rd & addr_hit(sfr_addr, `CSPM_PSW_ADDR);
	assign power_control_rd     = sfr_rd & addr_hit(sfr_addr, `CSPM_POWER_CONTROL_ADDR);
	// only a written one does anything; a zero leaves a pending mode alone
	assign idle_wr_one = power_control_wr & sfr_wdata[`CSPM_POWER_CONTROL_IDLE];
	assign stop_wr_one = power_control_wr & sfr_wdata[`CSPM_POWER_CONTROL_STOP];

	// mode entry waits for the writing instruction to finish
	assign go_idle = instr_done & (idle_arm_q | idle_wr_one);
	assign go_stop = instr_done & (stop_arm_q | stop_wr_one);

	// arm flags drop once acted upon; a write landing with instruction end acts at once and does not arm
	assign idle_arm_d = cpu_run & ((idle_arm_q & ~instr_done) | (idle_wr_one & ~instr_done));
	assign stop_arm_d = cpu_run & ((stop_arm_q & ~instr_done) | (stop_wr_one & ~instr_done));

	// watchdog is clocked in idle but not in stop, so it only counts here
	assign rst_idle = ext_rst_s | wdt_rst | (mcd_enable & mcd_rst_s);
	// in stop only the pin and the missing-clock monitor are alive
	assign rst_stop = ext_rst_s | (mcd_enable & mcd_rst_s);
	assign wake_irq = irq_pending;

	// reset sources as seen from the present state
	always_comb
	begin
		case (state_q)
			CSPM_RUN:  rst_any = rst_idle;
			CSPM_IDLE: rst_any = rst_idle;
			CSPM_STOP: rst_any = rst_stop;
			CSPM_SUSP: rst_any = rst_idle;
			default:   rst_any = rst_idle;
		endcase
	end

	// power state transitions; reset takes priority over every wake
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			CSPM_RUN:
			begin
				if (rst_any)
					state_d = CSPM_RUN;
				else if (go_stop)
					state_d = CSPM_STOP;
				else if (go_idle)
					state_d = CSPM_IDLE;
				else if (suspend_req)
					state_d = CSPM_SUSP;
			end
			CSPM_IDLE:
			begin
				// pc is frozen, so resuming lands after the idle write
				if (rst_any || wake_irq)
					state_d = CSPM_RUN;
			end
			CSPM_STOP:
			begin
				// interrupts are dead in stop, only reset leaves
				if (rst_any)
					state_d = CSPM_RUN;
			end
			CSPM_SUSP:
			begin
				if (rst_any || wake_s)
					state_d = CSPM_RUN;
			end
			default:
				state_d = CSPM_RUN;
		endcase
	end

	// status word next value; alu updates beat a same-cycle software write
	// and only a reset moves it while the cpu is halted so idle preserves contents
	always_comb
	begin
		psw_d = psw_q;
		if (rst_any)
			psw_d = `CSPM_PSW_RST;
		else if (cpu_run)
		begin
			if (psw_wr)
				psw_d = sfr_wdata[7:1];
			if (cy_we)
				psw_d[`CSPM_PSW_CY] = cy_in;
			if (ac_we)
				psw_d[`CSPM_PSW_AC] = ac_in;
			if (ov_we)
				psw_d[`CSPM_PSW_OV] = ov_in;
		end
	end

	// reserved bits keep what software writes, cleared by reset
	assign power_control_rsv_d = rst_any ? `CSPM_POWER_CONTROL_RSV_RST
	                  : power_control_wr ? sfr_wdata[`CSPM_POWER_CONTROL_RSV_HI:`CSPM_POWER_CONTROL_RSV_LO]
	                  : power_control_rsv_q;

	// read mux; mode bits never read back as one
	assign rdata_d = psw_rd  ? {psw_q, parity_q}
	               : power_control_rd ? {power_control_rsv_q, 2'b00}
	               : `CSPM_RDATA_RST;

	// state register
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			state_q <= CSPM_RUN;
		else
			state_q <= state_d;
	end

	// pending mode requests
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			idle_arm_q <= 1'b0;
			stop_arm_q <= 1'b0;
		end
		else
		begin
			idle_arm_q <= idle_arm_d & ~rst_any;
			stop_arm_q <= stop_arm_d & ~rst_any;
		end
	end

	// status word and reserved storage
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			psw_q      <= `CSPM_PSW_RST;
			power_control_rsv_q <= `CSPM_POWER_CONTROL_RSV_RST;
		end
		else
		begin
			psw_q      <= psw_d;
			power_control_rsv_q <= power_control_rsv_d;
		end
	end

	// parity lags the accumulator by one cycle, fine for a status read
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			parity_q <= 1'b0;
		else
			parity_q <= ^acc_value;
	end

	// register bank base follows the next bank select bits
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			bank_base <= `CSPM_BANK_RST;
		else
			bank_base <= {psw_d[`CSPM_PSW_RSH], psw_d[`CSPM_PSW_RSL], `CSPM_BANK_PAD};
	end

	// visible status word and read data
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			psw_value <= {`CSPM_PSW_RST, 1'b0};
			sfr_rdata <= `CSPM_RDATA_RST;
		end
		else
		begin
			psw_value <= {psw_d, ^acc_value};
			sfr_rdata <= rdata_d;
		end
	end

	// clock gating: idle drops only the cpu clock, stop drops everything
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cpu_clk_en    <= 1'b1;
			sys_clk_en    <= 1'b1;
			periph_clk_en <= 1'b1;
			osc_en        <= 1'b1;
		end
		else
		begin
			cpu_clk_en    <= (state_d == CSPM_RUN);
			sys_clk_en    <= (state_d != CSPM_STOP) && (state_d != CSPM_SUSP);
			periph_clk_en <= (state_d != CSPM_STOP) && (state_d != CSPM_SUSP);
			osc_en        <= (state_d != CSPM_STOP) && (state_d != CSPM_SUSP);
		end
	end

	// restart request and interrupt resume pulses
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			core_rst     <= 1'b0;
			irq_resume   <= 1'b0;
			restart_addr <= `CSPM_RESET_VEC;
		end
		else
		begin
			core_rst     <= rst_any;
			irq_resume   <= (state_q == CSPM_IDLE) & wake_irq & ~rst_any;
			restart_addr <= `CSPM_RESET_VEC;
		end
	end

	// mode indicators
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_idle <= 1'b0;
			mode_stop <= 1'b0;
			mode_susp <= 1'b0;
		end
		else
		begin
			mode_idle <= (state_d == CSPM_IDLE);
			mode_stop <= (state_d == CSPM_STOP);
			mode_susp <= (state_d == CSPM_SUSP);
		end
	end

endmodule
`default_nettype wire

// ===== verification/cspm_checker.sv
`timescale 1ns/100ps
`default_nettype none
// watches mode, clock gating and status word outputs
module cspm_checker
(
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        instr_done,
	input wire logic        irq_pending,
	input wire logic        wdt_rst,
	input wire logic [7:0]  acc_value,
	input wire logic [7:0]  psw_value,
	input wire logic        cpu_clk_en,
	input wire logic        osc_en,
	input wire logic        core_rst,
	input wire logic [15:0] restart_addr,
	input wire logic        mode_idle,
	input wire logic        mode_stop
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// stop write at instruction end while running; any same-cycle reset cancels it
	wire                    stop_go;
	assign stop_go = cpu_clk_en && sfr_wr && instr_done
		&& sfr_addr == 8'h87 && sfr_wdata[1];
	a_stop_entry_done: assert property (stop_go |=> mode_stop || core_rst)
		else $error("stop not entered after write");
	a_idle_cpu_gate: assert property (mode_idle |-> !cpu_clk_en && osc_en)
		else $error("idle clock gating wrong");
	a_irq_ends_idle: assert property (mode_idle && irq_pending |=> !mode_idle)
		else $error("interrupt did not end idle");
	a_wdt_ends_idle: assert property (mode_idle && wdt_rst |=> core_rst && !mode_idle)
		else $error("watchdog did not end idle");
	a_restart_at_zero: assert property (core_rst |-> restart_addr == 16'h0000)
		else $error("restart address not zero");
	a_stop_all_off: assert property (mode_stop |-> !cpu_clk_en && !osc_en)
		else $error("clocks running in stop");
	a_stop_needs_reset: assert property ($fell(mode_stop) |-> core_rst)
		else $error("stop left without reset");
	a_mode_bits_zero: assert property (sfr_rd && sfr_addr == 8'h87 |=> sfr_rdata[1:0] == 2'h0)
		else $error("mode bits read nonzero");
	a_parity_follows: assert property (1'b1 |=> psw_value[0] == ^$past(acc_value))
		else $error("parity flag wrong");
endmodule
bind cspm_top cspm_checker chk_u (.*);
`default_nettype wire

// ===== verification/cspm_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cspm_top_tb_top;
	logic        clk = 1'b0, arst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, instr_done = 1'b0;
	logic        irq_pending = 1'b0, ext_rst_pin_n = 1'b1, wdt_rst = 1'b0, mcd_rst = 1'b0;
	logic        mcd_enable = 1'b0, suspend_req = 1'b0, wake_event = 1'b0, rd_q = 1'b0;
	logic        cy_we = 1'b0, cy_in = 1'b0, ac_we = 1'b0, ac_in = 1'b0, ov_we = 1'b0, ov_in = 1'b0;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, acc_value = 8'h00, sfr_rdata, psw_value;
	logic [4:0]  bank_base;
	logic [15:0] restart_addr;
	logic        cpu_clk_en, sys_clk_en, periph_clk_en, osc_en, core_rst, irq_resume;
	logic        mode_idle, mode_stop, mode_susp;
	logic [31:0] rng = 32'h8888;
	logic [7:0]  expq[$];   // expected read data, oldest first
	int          n_fail = 0, check_count = 0, cyc = 0, i, k;

	cspm_top dut_u (.*);

	always #4 clk = ~clk;

	// hang guard, far above the hundred or so cycles needed
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	// read data lands one cycle after the read edge
	always @(posedge clk)
		rd_q <= sfr_rd;
	always @(negedge clk)
		if (rd_q)
			chk("rdata", sfr_rdata, expq.pop_front());

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one-cycle write strobe, released a cycle later
	task sfr_w(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task sfr_r(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		expq.push_back(e);
		@(negedge clk);
		sfr_rd = 1'b0;
	endtask

	// stop writes end their instruction at once, idle writes a cycle later
	task go(input logic [7:0] d);
		instr_done = d[1];
		// reserved bits always written as zero
		sfr_w(8'h87, d);
		chk("early", mode_idle, 1'b0);
		// idle write is followed by a longer instruction ending here
		instr_done = 1'b1;
		@(negedge clk);
		instr_done = 1'b0;
	endtask

	task tally_and_finish();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		acc_value = 8'h07;
		// reset values and an unmapped address
		sfr_r(8'hD0, 8'h01);
		sfr_r(8'h87, 8'h00);
		sfr_r(8'h55, 8'h00);
		$display("test 1 done");
		// every bank code with random other bits
		for (i = 0; i < 4; i++)
		begin
			rng = lfsr(rng);
			acc_value = rng[15:8];
			sfr_w(8'hD0, {rng[7:5], i[1:0], rng[2:0]});
			chk("bank", bank_base, {i[1:0], 3'h0});
			chk("psw", psw_value[7:1], {rng[7:5], i[1:0], rng[2:1]});
			sfr_r(8'hD0, {rng[7:5], i[1:0], rng[2:1], ^rng[15:8]});
		end
		// alu flag strobes after clearing the word
		sfr_w(8'hD0, 8'h00);
		{cy_we, cy_in, ac_we, ac_in, ov_we, ov_in} = 6'h3F;
		@(negedge clk);
		{cy_we, ac_we, ov_we} = 3'h0;
		sfr_r(8'hD0, {7'h62, ^acc_value});
		$display("test 2 done");
		// idle: writes refused, interrupt wakes; watchdog kept quiet so idle holds
		go(8'h01);
		chk("idle", {mode_idle, cpu_clk_en, periph_clk_en, osc_en}, 4'hB);
		sfr_w(8'hD0, 8'h18);
		sfr_r(8'hD0, {7'h62, ^acc_value});
		irq_pending = 1'b1;
		@(negedge clk);
		irq_pending = 1'b0;
		chk("irq wake", {irq_resume, mode_idle, cpu_clk_en}, 3'h5);
		$display("test 3 done");
		// reset wake: idle by wdt and pin, stop by pin and monitor
		for (i = 0; i < 4; i++)
		begin
			// analog side lives outside this block, nothing to shut before stop
			go(i < 2 ? 8'h01 : 8'h02);
			chk("mode", {mode_idle, mode_stop, sys_clk_en, osc_en}, i < 2 ? 4'hB : 4'h4);
			if (i > 1)
			begin
				{irq_pending, wdt_rst} = 2'h3;
				@(negedge clk);
				{irq_pending, wdt_rst} = 2'h0;
				chk("stop hold", mode_stop, 1'b1);
			end
			wdt_rst = (i == 0);
			ext_rst_pin_n = !(i == 1 || i == 2);
			mcd_enable = 1'b1;
			mcd_rst = (i == 3);
			for (k = 0; k < 8 && core_rst !== 1'b1; k++)
				@(negedge clk);
			chk("rst wake", {core_rst, mode_idle, mode_stop, restart_addr}, 32'h40000);
			{wdt_rst, mcd_rst, ext_rst_pin_n} = 3'h1;
			repeat (5) @(negedge clk);
			sfr_r(8'hD0, {7'h00, ^acc_value});
		end
		$display("test 4 done");
		// suspend until a wake event
		suspend_req = 1'b1;
		@(negedge clk);
		suspend_req = 1'b0;
		chk("susp", {mode_susp, osc_en, cpu_clk_en}, 3'h4);
		wake_event = 1'b1;
		for (k = 0; k < 8 && mode_susp !== 1'b0; k++)
			@(negedge clk);
		wake_event = 1'b0;
		chk("susp wake", {mode_susp, osc_en, cpu_clk_en}, 3'h3);
		$display("test 5 done");
		repeat (2) @(negedge clk);
		tally_and_finish();
	end
endmodule
`default_nettype wire
